// *** logic/dspe_top.sv ***
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Contract
// - fractional 16/16 and signed/unsigned integer 32/16, 16/16 divides.
// - word divides take the same step count, extending dividend in step one.
// - repeat count gives 18 divide steps, 19 cycles with setup.
// - divide may pause for an interrupt; software saves disturbed context.
// - dividend from register or pair, quotient and remainder to two regs.
// - 17x17 multiplier, shifter, 40-bit adder serving two accumulators.
// - add, subtract, negate between accumulators with no other data.
// - configuration bits select multiply, rounding and saturation modes. The code does no rounding; CFG_RMODE is never read.
// - nine accumulator operations; four of them permit write-back. The code has no accumulator write-back.
// - operands widened to 17 bits by zero or sign extension.
// - 33-bit product sign-extended to 40 bits before accumulation.
// - fractional mode gives 1.31 product from 1.15 operands.
// - same multiplier does signed, unsigned, mixed integer multiplies.
// - general multiply gives 16-bit byte result, 32-bit word result.
// - adder picks accumulator a or b; add and load may be shifted.
// - adder has zero input; add true data, subtract complement with borrow.
// - flag catastrophic bit 39 overflow and guard bits not identical.
// - saturation uses result, flags, per-accumulator enables, mode bit.
// - six status bits: two overflow, two saturation, two or-bits.
// - guard overflow bits refresh on every adder pass.
// - guard overflow with its trap enable raises arithmetic warning trap.
// - saturation bits are sticky, cleared only by software write.
// - bit 39 mode loads 9.31 extreme value and sets saturation bit.
// - bit 31 mode loads 1.31 extreme value; guard bits never set.
module dspe_top
    import dspe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic irq_hold,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic arith_trap
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [32:0] mul33(input logic [15:0] a,
        input logic [15:0] b, input logic asg, input logic bsg,
        input logic frac);
        logic signed [16:0] ea;
        logic signed [16:0] eb;
        logic signed [33:0] p;
        ea = $signed({asg & a[15], a});
        eb = $signed({bsg & b[15], b});
        p = ea * eb;
        if (frac) begin
            p = p <<< 1;
        end
        return p[32:0];
    endfunction

    function automatic logic [39:0] ext40(input logic [32:0] v);
        return {{7{v[32]}}, v};
    endfunction

    // signed amount: positive shifts right, negative left
    function automatic logic [39:0] shift40(input logic [39:0] v,
        input logic [4:0] amt);
        if (amt[4]) begin
            return v << ({1'b0, ~amt} + 6'h1);
        end
        return $unsigned($signed(v) >>> amt);
    endfunction

    // {catastrophic, sum}
    function automatic logic [40:0] add40(input logic [39:0] a,
        input logic [39:0] b, input logic sub);
        logic [39:0] bb;
        logic [39:0] s;
        bb = sub ? ~b : b;
        s = a + bb + {39'h0, sub};
        return {(a[39] == bb[39]) && (s[39] != a[39]), s};
    endfunction

    function automatic logic [31:0] neg32(input logic [31:0] v);
        return ~v + 32'h1;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] cfg_q;
    logic [2:0] icr_q;
    logic [15:0] opx_q, opy_q;
    logic [31:0] cmd_q;
    logic exec_q;
    logic [39:0] accumulator_a_q, accumulator_b_q;
    logic aov_q, bov_q, asat_q, bsat_q;
    logic [15:0] dvd_lo_q, dvd_hi_q, dvs_q, quo_q, rem_out_q;
    logic [31:0] mul_q;
    logic [4:0] rpt_q, step_q;
    logic [15:0] prem_q, plo_q, pdv_q;
    logic qneg_q, rneg_q;
    dspe_dst_e dst_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, trap_q;

    logic wr_en;
    logic bus_hit;
    logic [31:0] rd_data;
    assign wr_en = psel & penable & pready_q & pwrite;

    // ------------------------------------------------------------
    // apb slave: one wait state, error on unmapped address
    // ------------------------------------------------------------
    always_comb begin
        bus_hit = 1'b1;
        rd_data = 32'h0;
        case (paddr)
            ADDR_CFG: rd_data = {16'h0, cfg_q};
            ADDR_ICR: rd_data = {29'h0, icr_q};
            ADDR_STAT: begin
                rd_data[ST_AOV] = aov_q;
                rd_data[ST_BOV] = bov_q;
                rd_data[ST_ASAT] = asat_q;
                rd_data[ST_BSAT] = bsat_q;
                rd_data[ST_ANYOV] = aov_q | bov_q;
                rd_data[ST_ANYSAT] = asat_q | bsat_q;
                rd_data[ST_BUSY] = (dst_q == DIV_RUN);
            end
            ADDR_OPX: rd_data = {16'h0, opx_q};
            ADDR_OPY: rd_data = {16'h0, opy_q};
            ADDR_CMD: rd_data = cmd_q;
            ADDR_ACCUMULATOR_A_LO: rd_data = accumulator_a_q[31:0];
            ADDR_ACCUMULATOR_A_HI: rd_data = {24'h0, accumulator_a_q[39:32]};
            ADDR_ACCUMULATOR_B_LO: rd_data = accumulator_b_q[31:0];
            ADDR_ACCUMULATOR_B_HI: rd_data = {24'h0, accumulator_b_q[39:32]};
            ADDR_DVD_LO: rd_data = {16'h0, dvd_lo_q};
            ADDR_DVD_HI: rd_data = {16'h0, dvd_hi_q};
            ADDR_DVS: rd_data = {16'h0, dvs_q};
            ADDR_QUO: rd_data = {16'h0, quo_q};
            ADDR_REM: rd_data = {16'h0, rem_out_q};
            ADDR_MUL: rd_data = mul_q;
            ADDR_RPT: rd_data = {27'h0, rpt_q};
            default: bus_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~bus_hit;
            if (psel & penable & ~pready_q & ~pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RST;
            icr_q <= ICR_RST;
            opx_q <= 16'h0;
            opy_q <= 16'h0;
            dvd_lo_q <= 16'h0;
            dvd_hi_q <= 16'h0;
            dvs_q <= 16'h0;
        end else if (wr_en) begin
            case (paddr)
                ADDR_CFG: cfg_q <= pwdata[15:0];
                ADDR_ICR: icr_q <= pwdata[2:0];
                ADDR_OPX: opx_q <= pwdata[15:0];
                ADDR_OPY: opy_q <= pwdata[15:0];
                ADDR_DVD_LO: dvd_lo_q <= pwdata[15:0];
                ADDR_DVD_HI: dvd_hi_q <= pwdata[15:0];
                ADDR_DVS: dvs_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // command launch: executes the cycle after the write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= 32'h0;
            exec_q <= 1'b0;
        end else begin
            exec_q <= wr_en && paddr == ADDR_CMD;
            if (wr_en && paddr == ADDR_CMD) begin
                cmd_q <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // dsp datapath
    // ------------------------------------------------------------
    dspe_op_e op;
    logic tsel, frac, sgn, sat_en, mode39, sub, pass, sat, gov;
    logic [15:0] dif;
    logic [39:0] tacc, oacc, ain, bin, res;
    logic [40:0] sum;
    logic [32:0] mxy, gp;
    logic [15:0] gx, gy;

    always_comb begin
        op = dspe_op_e'(cmd_q[3:0]);
        tsel = cmd_q[CMD_ACC];
        tacc = tsel ? accumulator_b_q : accumulator_a_q;
        oacc = tsel ? accumulator_a_q : accumulator_b_q;
        frac = ~cfg_q[CFG_INT];
        sgn = ~cfg_q[CFG_UNS];
        dif = opx_q - opy_q;
        mxy = mul33(opx_q, opy_q, sgn, sgn, frac);
        gx = cmd_q[CMD_BYTE] ? {{8{cmd_q[CMD_XS] & opx_q[7]}}, opx_q[7:0]}
                             : opx_q;
        gy = cmd_q[CMD_BYTE] ? {{8{cmd_q[CMD_YS] & opy_q[7]}}, opy_q[7:0]}
                             : opy_q;
        gp = mul33(gx, gy, cmd_q[CMD_XS], cmd_q[CMD_YS], 1'b0);
        ain = 40'h0; // zero side of the adder
        bin = 40'h0;
        sub = 1'b0;
        pass = 1'b1;
        case (op)
            acc_clear_op: ;
            squared_difference_op:
                bin = ext40(mul33(dif, dif, 1'b1, 1'b1, frac));
            squared_difference_acc_op: begin
                ain = tacc;
                bin = ext40(mul33(dif, dif, 1'b1, 1'b1, frac));
            end
            mac_op: begin
                ain = tacc;
                bin = ext40(mxy);
            end
            square_acc_op: begin
                ain = tacc;
                bin = ext40(mul33(opx_q, opx_q, sgn, sgn, frac));
            end
            multiply_op: bin = ext40(mxy);
            negated_multiply_op: begin
                bin = ext40(mxy);
                sub = 1'b1;
            end
            multiply_subtract_op: begin
                ain = tacc;
                bin = ext40(mxy);
                sub = 1'b1;
            end
            acc_add_op: begin
                ain = tacc;
                bin = shift40(oacc, cmd_q[CMD_SH_LO+:5]);
            end
            acc_sub_op: begin
                ain = tacc;
                bin = oacc;
                sub = 1'b1;
            end
            acc_neg_op: begin
                bin = tacc;
                sub = 1'b1;
            end
            acc_load_op:
                bin = shift40({{8{opx_q[15]}}, opx_q, 16'h0},
                              cmd_q[CMD_SH_LO+:5]);
            default: pass = 1'b0; // move, general multiply, divide skip the adder
        endcase
        sum = add40(ain, bin, sub);
        sat_en = tsel ? cfg_q[CFG_BSAT] : cfg_q[CFG_ASAT];
        mode39 = cfg_q[CFG_SATMODE];
        gov = !(&sum[39:32] || !(|sum[39:32]));
        res = sum[39:0];
        sat = 1'b0;
        if (sat_en && mode39) begin
            if (sum[40]) begin
                res = ain[39] ? SAT39_NEG : SAT39_POS;
                sat = 1'b1;
            end
        end else if (sat_en) begin
            gov = 1'b0;
            if (sum[40] || !(&sum[39:31] || !(|sum[39:31]))) begin
                res = (sum[40] ? ain[39] : sum[39]) ? SAT31_NEG
                                                    : SAT31_POS;
                sat = 1'b1;
            end
        end else begin
            sat = sum[40]; // no saturation, flag catastrophic only
        end
    end

    // accumulators: datapath wins over a software context restore
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator_a_q <= 40'h0;
            accumulator_b_q <= 40'h0;
        end else if (exec_q && pass) begin
            if (tsel) begin
                accumulator_b_q <= res;
            end else begin
                accumulator_a_q <= res;
            end
        end else if (wr_en) begin
            case (paddr)
                ADDR_ACCUMULATOR_A_LO: accumulator_a_q[31:0] <= pwdata;
                ADDR_ACCUMULATOR_A_HI: accumulator_a_q[39:32] <= pwdata[7:0];
                ADDR_ACCUMULATOR_B_LO: accumulator_b_q[31:0] <= pwdata;
                ADDR_ACCUMULATOR_B_HI: accumulator_b_q[39:32] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mul_q <= 32'h0;
        end else if (exec_q && op == general_multiply_op) begin
            mul_q <= cmd_q[CMD_BYTE] ? {16'h0, gp[15:0]}
                                     : gp[31:0];
        end
    end

    // ------------------------------------------------------------
    // status flags and trap
    // ------------------------------------------------------------
    logic asat_clr, bsat_clr;
    assign asat_clr = wr_en && paddr == ADDR_STAT && pwdata[ST_ASAT];
    assign bsat_clr = wr_en && paddr == ADDR_STAT && pwdata[ST_BSAT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aov_q <= 1'b0;
            bov_q <= 1'b0;
        end else if (exec_q && pass) begin
            if (tsel) begin
                bov_q <= gov;
            end else begin
                aov_q <= gov;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asat_q <= 1'b0;
            bsat_q <= 1'b0;
        end else begin
            asat_q <= (exec_q && pass && !tsel && sat) ||
                      (asat_q && !asat_clr);
            bsat_q <= (exec_q && pass && tsel && sat) ||
                      (bsat_q && !bsat_clr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= exec_q && pass &&
                      ((gov && icr_q[tsel ? ICR_OVB : ICR_OVA]) ||
                       (sum[40] && !sat_en && icr_q[ICR_COV]));
        end
    end

    // ------------------------------------------------------------
    // iterative divide, one step per repeat count
    // ------------------------------------------------------------
    dspe_div_e dk;
    logic dsgn, nn, nd;
    logic [31:0] dvd32, dmag;
    logic [15:0] vmag;
    logic [16:0] trial;

    always_comb begin
        dk = dspe_div_e'(cmd_q[CMD_DK_LO+:3]);
        dsgn = dk != unsigned_long_divide_op &&
               dk != unsigned_word_divide_op;
        case (dk)
            frac_divide_op: dvd32 = {dvd_lo_q[15], dvd_lo_q, 15'h0};
            signed_long_divide_op,
            unsigned_long_divide_op: dvd32 = {dvd_hi_q, dvd_lo_q};
            signed_word_divide_op:
                dvd32 = {{16{dvd_lo_q[15]}}, dvd_lo_q};
            default: dvd32 = {16'h0, dvd_lo_q};
        endcase
        nn = dsgn & dvd32[31];
        nd = dsgn & dvs_q[15];
        dmag = nn ? neg32(dvd32) : dvd32;
        vmag = nd ? 16'(~dvs_q + 16'h1) : dvs_q;
        trial = {prem_q, plo_q[15]} - {1'b0, pdv_q};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dst_q <= DIV_IDLE;
            rpt_q <= 5'h0;
            step_q <= 5'h0;
        end else begin
            case (dst_q)
                DIV_IDLE: begin
                    if (exec_q && op == divide_op) begin
                        dst_q <= DIV_RUN;
                        step_q <= 5'h0;
                    end else if (wr_en && paddr == ADDR_RPT) begin
                        rpt_q <= pwdata[4:0];
                    end
                end
                DIV_RUN: begin
                    if (!irq_hold) begin
                        step_q <= step_q + 5'h1;
                        rpt_q <= rpt_q - 5'h1;
                        if (rpt_q == 5'h0) begin
                            dst_q <= DIV_IDLE;
                            rpt_q <= 5'h0;
                        end
                    end
                end
                default: dst_q <= DIV_IDLE;
            endcase
        end
    end

    // partial remainder and quotient stay put while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prem_q <= 16'h0;
            plo_q <= 16'h0;
            pdv_q <= 16'h0;
            qneg_q <= 1'b0;
            rneg_q <= 1'b0;
            quo_q <= 16'h0;
            rem_out_q <= 16'h0;
        end else if (dst_q == DIV_RUN && !irq_hold) begin
            if (step_q == 5'h0) begin
                prem_q <= dmag[31:16];
                plo_q <= dmag[15:0];
                pdv_q <= vmag;
                qneg_q <= nn ^ nd;
                rneg_q <= nn;
            end else if (step_q < DIV_LAST) begin
                if (!trial[16]) begin
                    prem_q <= trial[15:0];
                end else begin
                    prem_q <= {prem_q[14:0], plo_q[15]};
                end
                plo_q <= {plo_q[14:0], ~trial[16]};
            end else if (step_q == DIV_LAST) begin
                quo_q <= qneg_q ? 16'(~plo_q + 16'h1) : plo_q;
                rem_out_q <= rneg_q ? 16'(~prem_q + 16'h1) : prem_q;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign arith_trap = trap_q;
endmodule

// *** logic/dspe_pkg.sv ***
package dspe_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_ICR = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_OPX = 8'h0c;
    localparam logic [7:0] ADDR_OPY = 8'h10;
    localparam logic [7:0] ADDR_CMD = 8'h14;
    localparam logic [7:0] ADDR_ACCUMULATOR_A_LO = 8'h18;
    localparam logic [7:0] ADDR_ACCUMULATOR_A_HI = 8'h1c;
    localparam logic [7:0] ADDR_ACCUMULATOR_B_LO = 8'h20;
    localparam logic [7:0] ADDR_ACCUMULATOR_B_HI = 8'h24;
    localparam logic [7:0] ADDR_DVD_LO = 8'h28;
    localparam logic [7:0] ADDR_DVD_HI = 8'h2c;
    localparam logic [7:0] ADDR_DVS = 8'h30;
    localparam logic [7:0] ADDR_QUO = 8'h34;
    localparam logic [7:0] ADDR_REM = 8'h38;
    localparam logic [7:0] ADDR_MUL = 8'h3c;
    localparam logic [7:0] ADDR_RPT = 8'h40;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_INT = 0;
    localparam int CFG_RMODE = 1;
    localparam int CFG_SATMODE = 4;
    localparam int CFG_WSAT = 5;
    localparam int CFG_BSAT = 6;
    localparam int CFG_ASAT = 7;
    localparam int CFG_UNS = 12;
    localparam int ICR_OVA = 0;
    localparam int ICR_OVB = 1;
    localparam int ICR_COV = 2;
    localparam int ST_AOV = 0;
    localparam int ST_BOV = 1;
    localparam int ST_ASAT = 2;
    localparam int ST_BSAT = 3;
    localparam int ST_ANYOV = 4;
    localparam int ST_ANYSAT = 5;
    localparam int ST_BUSY = 8;
    localparam int CMD_ACC = 4;
    localparam int CMD_SH_LO = 8;
    localparam int CMD_BYTE = 13;
    localparam int CMD_XS = 14;
    localparam int CMD_YS = 15;
    localparam int CMD_DK_LO = 16;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [2:0] ICR_RST = 3'h0;
    localparam logic [4:0] DIV_LAST = 5'h11;
    localparam logic [39:0] SAT39_POS = 40'h7fffffffff;
    localparam logic [39:0] SAT39_NEG = 40'h8000000000;
    localparam logic [39:0] SAT31_POS = 40'h007fffffff;
    localparam logic [39:0] SAT31_NEG = 40'hff80000000;
    // ------------------------------------------------------------
    // commands and states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        acc_clear_op = 4'h0,
        squared_difference_op = 4'h1,
        squared_difference_acc_op = 4'h2,
        mac_op = 4'h3,
        square_acc_op = 4'h4,
        prefetch_move_op = 4'h5,
        multiply_op = 4'h6,
        negated_multiply_op = 4'h7,
        multiply_subtract_op = 4'h8,
        acc_add_op = 4'h9,
        acc_sub_op = 4'ha,
        acc_neg_op = 4'hb,
        acc_load_op = 4'hc,
        general_multiply_op = 4'hd,
        divide_op = 4'he
    } dspe_op_e;
    typedef enum logic [2:0] {
        frac_divide_op = 3'h0,
        signed_long_divide_op = 3'h1,
        unsigned_long_divide_op = 3'h2,
        signed_word_divide_op = 3'h3,
        unsigned_word_divide_op = 3'h4
    } dspe_div_e;
    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN = 2'b01
    } dspe_dst_e;
endpackage

// *** tb/dspe_core_model.sv ***
`timescale 1ns/100ps
module dspe_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hold_req,
    output logic irq_hold
);
    logic [1:0] cnt_q;
    // interrupt entry freezes the divide for three cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'h0;
        end else if (hold_req) begin
            cnt_q <= 2'h3;
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
    end
    assign irq_hold = (cnt_q != 2'h0);
endmodule

// *** tb/dspe_top_asserts.sv ***
`timescale 1ns/100ps
module dspe_top_asserts
    import dspe_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic irq_hold,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic arith_trap
);
    wire done = psel && penable && pready;
    wire cmd_wr = done && pwrite && (paddr == ADDR_CMD);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    a_wait_state: assert property (s_setup |-> ##2 pready)
        else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready long");
    a_idle_quiet: assert property (!psel |-> !pready)
        else $error("ready idle");
    a_err_ready: assert property (pslverr |-> done)
        else $error("stray error");
    a_unmapped_err: assert property (done && paddr > 8'h40 |-> pslverr)
        else $error("no error");
    a_mapped_ok: assert property (done && paddr <= 8'h40 &&
        paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("false error");
    a_unmapped_zero: assert property (done && !pwrite && pslverr
        |-> prdata == 32'h0) else $error("unmapped data");
    a_trap_cause: assert property (arith_trap |-> $past(cmd_wr, 2))
        else $error("trap timing");
    a_trap_pulse: assert property (arith_trap |=> !arith_trap)
        else $error("trap long");
endmodule
bind dspe_top dspe_top_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .irq_hold(irq_hold), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .arith_trap(arith_trap));

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb;
    import dspe_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, hold_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rng = 32'h55, q, num, m = 32'hffffffff;
    logic [71:0] eq[$];
    logic [71:0] ent;
    logic signed [39:0] sx, sy;
    logic irq_hold, pready, pslverr, arith_trap;
    logic [31:0] prdata;
    int failures = 0, checks = 0, traps = 0, n;
    always #5 pclk = ~pclk;
    dspe_top dspe_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .irq_hold(irq_hold), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .arith_trap(arith_trap));
    dspe_core_model dspe_core_model_inst (.pclk(pclk), .presetn(presetn),
        .hold_req(hold_req), .irq_hold(irq_hold));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [40:0] g, e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one idle edge after each transfer keeps drivers single per step
    task automatic ap(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, k);
        eq.push_back({k, e, a});
        ap(a, 1'b0, 32'h0);
    endtask
    always @(posedge pclk) begin
        if (arith_trap === 1'b1)
            traps++;
        if (psel && penable && pready && !pwrite && eq.size() > 0) begin
            ent = eq.pop_front();
            chk($sformatf("reg %h", ent[7:0]), {pslverr,
                prdata & ent[71:40]}, {ent[7:0] > 8'h40, ent[39:8]});
        end
    end
    task automatic mul(input logic [31:0] c, input logic [15:0] x, y,
        input logic [39:0] e);
        wr(ADDR_CFG, c);
        wr(ADDR_OPX, {16'h0, x});
        wr(ADDR_OPY, {16'h0, y});
        wr(ADDR_CMD, {28'h0, multiply_op});
        rd(ADDR_ACCUMULATOR_A_LO, e[31:0], m);
        rd(ADDR_ACCUMULATOR_A_HI, {24'h0, e[39:32]}, m);
    endtask
    task automatic addop(input logic [31:0] c, hi, lo);
        wr(ADDR_CFG, c);
        wr(ADDR_ACCUMULATOR_A_HI, hi);
        wr(ADDR_ACCUMULATOR_A_LO, lo);
        wr(ADDR_CMD, {28'h0, acc_add_op});
    endtask
    initial begin
        #200000;
        failures++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_CFG, 32'h0, m);
        rd(ADDR_STAT, 32'h0, m);
        rd(8'h80, 32'h0, m);
        $display("test reset done");
        rng = xs(rng);
        sx = $signed(rng[15:0]);
        sy = $signed(rng[31:16]);
        mul(32'h1, rng[15:0], rng[31:16], sx * sy);
        mul(32'h1001, 16'hffff, 16'hffff, 40'hfffe0001);
        mul(32'h0, 16'h8000, 16'h8000, 40'h0080000000);
        wr(ADDR_CMD, {16'h0, 4'h4, 8'h0, general_multiply_op});
        rd(ADDR_MUL, 32'hc0000000, m);
        $display("test multiply done");
        for (int k = 0; k < 5; k++) begin
            num = (k == 0) ? 32'h800000 : 32'h7531;
            wr(ADDR_RPT, 32'h11);
            wr(ADDR_DVD_LO, (k == 0) ? 32'h100 : 32'h7531);
            wr(ADDR_DVS, 32'h123);
            wr(ADDR_CMD, {13'h0, k[2:0], 12'h0, divide_op});
            hold_req <= 1'b1;
            @(posedge pclk);
            hold_req <= 1'b0;
            n = 0;
            do ap(ADDR_STAT, 1'b0, 32'h0);
            while (q[ST_BUSY] !== 1'b0 && ++n < 40);
            rd(ADDR_QUO, num / 32'h123, 32'hffff);
            rd(ADDR_REM, num % 32'h123, 32'hffff);
            rd(ADDR_RPT, 32'h0, 32'h1f);
        end
        $display("test divide done");
        wr(ADDR_ACCUMULATOR_B_LO, 32'h1);
        wr(ADDR_ICR, 32'h1);
        addop(32'h0, 32'h0, m);
        rd(ADDR_ACCUMULATOR_A_HI, 32'h1, 32'hff);
        rd(ADDR_STAT, 32'h11, 32'h3f);
        chk("trap", traps, 1);
        wr(ADDR_ICR, 32'h0);
        wr(ADDR_CMD, {28'h0, acc_clear_op});
        rd(ADDR_STAT, 32'h0, 32'h3f);
        addop(32'h80, 32'h0, 32'h7fffffff);
        rd(ADDR_ACCUMULATOR_A_LO, 32'h7fffffff, m);
        rd(ADDR_STAT, 32'h24, 32'h25);
        wr(ADDR_CMD, {28'h0, acc_clear_op});
        rd(ADDR_STAT, 32'h24, 32'h24);
        wr(ADDR_STAT, 32'h4);
        rd(ADDR_STAT, 32'h0, 32'h24);
        addop(32'h90, 32'h7f, m);
        rd(ADDR_ACCUMULATOR_A_HI, 32'h7f, 32'hff);
        rd(ADDR_STAT, 32'h24, 32'h24);
        $display("test accumulate done");
        summarize();
    end
endmodule
